// ==== hdl/sdbrc_bank.sv ====
`timescale 1ns/100ps
// ************************************************************
// one bank: idle / active with open row / precharging
// ************************************************************
module sdbrc_bank
	import sdbrc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic act,
	input wire logic col,
	input wire logic auto_pre,
	input wire logic pre,
	input wire logic [sdbrc_pkg::ROW_W-1:0] row,
	input wire logic [7:0] trp,
	output sdbrc_pkg::sdbrc_bank_state_t state,
	output logic [sdbrc_pkg::ROW_W-1:0] open_row,
	output logic access_ok,
	output logic err
);
	logic [7:0] cnt_reg;
	logic reopen;

	// column access only lands on an open row
	assign access_ok = col && (state == BANK_ACTIVE);

	// the precharge time has run out on this tick, so an activate may land now
	assign reopen = (state == BANK_PRECHARGING) && (cnt_reg <= 8'h01);

	// state walk; illegal commands leave the bank untouched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= BANK_IDLE;
			cnt_reg <= 8'h00;
		end else if (pre) begin
			// restart the period from the latest precharge
			if (state != BANK_IDLE || cnt_reg != 8'h00) begin
				state <= BANK_PRECHARGING;
				cnt_reg <= trp;
			end
		end else begin
			case (state)
				BANK_IDLE: begin
					if (act) begin
						state <= BANK_ACTIVE;
					end
				end
				BANK_ACTIVE: begin
					if (col && auto_pre) begin
						state <= BANK_PRECHARGING;
						cnt_reg <= trp;
					end
				end
				BANK_PRECHARGING: begin
					// idle only once the row precharge time has run out
					if (tick) begin
						if (cnt_reg <= 8'h01) begin
							state <= act ? BANK_ACTIVE : BANK_IDLE;
							cnt_reg <= 8'h00;
						end else begin
							cnt_reg <= cnt_reg - 8'h01;
						end
					end
				end
				default: begin
					state <= BANK_IDLE;
				end
			endcase
		end
	end

	// row held until the next activate lands on this bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_row <= '0;
		end else if (act && (state == BANK_IDLE || reopen) && !pre) begin
			open_row <= row;
		end
	end

	// flag misuse without hanging: act on busy bank, access on closed bank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err <= 1'b0;
		end else begin
			err <= (act && state != BANK_IDLE && !reopen) || (col && state != BANK_ACTIVE);
		end
	end
endmodule

// ==== hdl/sdbrc_pkg.sv ====
package sdbrc_pkg;

	// ************************************************************
	// command/address layout
	// ************************************************************
	localparam int BANK_W = 3;
	localparam int ROW_W = 14;
	localparam int COL_W = 10;
	localparam int NUM_BANKS = 8;
	localparam int ADDR_AP_BIT = 10;
	localparam int ADDR_BURST_BIT = 12;
	localparam int MR_AUTO_SR_BIT = 6;
	localparam int MR_TEMP_RANGE_BIT = 7;
	localparam logic [2:0] MR_TWO_BANK = 3'h2;

	// {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;

	// ************************************************************
	// timing in link clock cycles
	// ************************************************************
	localparam logic [2:0] CCD_CYCLES = 3'h4;
	localparam logic [7:0] TRP_RESET = 8'h06;

	// ************************************************************
	// self-refresh rate selection
	// ************************************************************
	localparam logic [1:0] SR_RATE_NORMAL = 2'h0;
	localparam logic [1:0] SR_RATE_EXT = 2'h1;
	localparam logic [1:0] SR_RATE_AUTO_COOL = 2'h2;
	localparam logic [1:0] SR_RATE_AUTO_HOT = 2'h3;

	// ************************************************************
	// apb register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TRP = 8'h04;
	localparam logic [7:0] REG_MODE = 8'h08;
	localparam logic [7:0] REG_BANKS = 8'h0c;
	localparam logic [7:0] REG_ERRS = 8'h10;
	localparam int CTRL_CLR_BIT = 0;

	typedef enum logic [1:0] {
		BANK_IDLE,
		BANK_ACTIVE,
		BANK_PRECHARGING
	} sdbrc_bank_state_t;

endpackage

// ==== hdl/sdbrc_sync.sv ====
`timescale 1ns/100ps
// ************************************************************
// two-stage synchroniser for a bundle of pin levels
// ************************************************************
module sdbrc_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ==== hdl/sdbrc_top.sv ====
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
// Operation
// - temp range bit 0, auto self-refresh off: normal-range self-refresh rate
// - temp range bit 1 selects a rate valid over normal and extended ranges
// - auto self-refresh on, temp range bit 0: temperature steers refresh power
// - activate opens the addressed row in the bank chosen by bank inputs
// - an open row stays open until that bank is precharged
// - a precharged bank reopens only after the row precharge time
// - precharge to an idle bank is accepted and ignored; to a precharging bank, period restarts
// - address bit 12 picks chop of four or full burst of eight
// - address bit 12 is never used as a column address bit
// - minor violations never lock the device, errors stay with that command
module sdbrc_top
	import sdbrc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ddr_ck,
	input wire logic ddr_cke,
	input wire logic ddr_cs_n,
	input wire logic ddr_ras_n,
	input wire logic ddr_cas_n,
	input wire logic ddr_we_n,
	input wire logic [sdbrc_pkg::BANK_W-1:0] ddr_ba,
	input wire logic [sdbrc_pkg::ROW_W-1:0] ddr_addr,
	input wire logic temp_hot,
	output logic [1:0] sr_rate,
	output logic sr_mode_illegal,
	output logic burst_valid,
	output logic burst_write,
	output logic burst_eight,
	output logic burst_auto_pre,
	output logic [sdbrc_pkg::BANK_W-1:0] burst_bank,
	output logic [sdbrc_pkg::ROW_W-1:0] burst_row,
	output logic [sdbrc_pkg::COL_W-1:0] burst_col
);
	import sdbrc_pkg::*;

	localparam int PIN_W = 7 + BANK_W + ROW_W;

	// ************************************************************
	// pin synchronisation and link clock edge detection
	// ************************************************************
	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins_sync;
	logic ck_s;
	logic cke_s;
	logic cs_n_s;
	logic ras_n_s;
	logic cas_n_s;
	logic we_n_s;
	logic hot_s;
	logic [BANK_W-1:0] ba_s;
	logic [ROW_W-1:0] addr_s;
	logic ck_prev_reg;
	logic tick;

	assign pins_raw = {ddr_ck, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n,
		temp_hot, ddr_ba, ddr_addr};

	sdbrc_sync #(.W(PIN_W)) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pins_raw),
		.q(pins_sync)
	);

	assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, hot_s, ba_s, addr_s} = pins_sync;

	// edge finder reads the synchronised level only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_prev_reg <= 1'b0;
		end else begin
			ck_prev_reg <= ck_s;
		end
	end

	// limitation: the link clock is oversampled, so it must run below a third of pclk
	// and the command pins must hold steady for a few pclk around its rising edge
	assign tick = ck_s && !ck_prev_reg;

	// ************************************************************
	// command decode
	// ************************************************************
	logic cmd_valid;
	logic [2:0] cmd_pins;
	logic is_act;
	logic is_pre;
	logic is_rd;
	logic is_wr;
	logic is_col;
	logic is_mrs;

	// one decoder for the command pins, shared by every command strobe
	function automatic logic cmd_is(input logic [2:0] pins, input logic [2:0] op);
		cmd_is = (pins == op);
	endfunction

	assign cmd_valid = tick && cke_s && !cs_n_s;
	assign cmd_pins = {ras_n_s, cas_n_s, we_n_s};
	assign is_act = cmd_valid && cmd_is(cmd_pins, CMD_ACT);
	assign is_pre = cmd_valid && cmd_is(cmd_pins, CMD_PRE);
	assign is_rd = cmd_valid && cmd_is(cmd_pins, CMD_RD);
	assign is_wr = cmd_valid && cmd_is(cmd_pins, CMD_WR);
	assign is_mrs = cmd_valid && cmd_is(cmd_pins, CMD_MRS);
	assign is_col = is_rd || is_wr;

	// ************************************************************
	// mode register two: self-refresh temperature handling
	// ************************************************************
	logic auto_self_refresh_reg;
	logic self_refresh_temp_range_reg;

	// the illegal pair is stored as written; the rate logic below falls back from it
	// only a mode set aimed at register two touches these bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_self_refresh_reg <= 1'b0;
			self_refresh_temp_range_reg <= 1'b0;
		end else if (is_mrs && ba_s == MR_TWO_BANK) begin
			auto_self_refresh_reg <= addr_s[MR_AUTO_SR_BIT];
			self_refresh_temp_range_reg <= addr_s[MR_TEMP_RANGE_BIT];
		end
	end

	// internal self-refresh rate; illegal combination falls back to the safe rate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_rate <= SR_RATE_NORMAL;
			sr_mode_illegal <= 1'b0;
		end else begin
			sr_mode_illegal <= auto_self_refresh_reg && self_refresh_temp_range_reg;
			if (self_refresh_temp_range_reg) begin
				sr_rate <= SR_RATE_EXT;
			end else if (auto_self_refresh_reg) begin
				sr_rate <= hot_s ? SR_RATE_AUTO_HOT : SR_RATE_AUTO_COOL;
			end else begin
				sr_rate <= SR_RATE_NORMAL;
			end
		end
	end

	// ************************************************************
	// banks
	// ************************************************************
	logic [7:0] trp_reg;
	sdbrc_bank_state_t bank_state [NUM_BANKS];
	logic [ROW_W-1:0] bank_row [NUM_BANKS];
	logic [NUM_BANKS-1:0] bank_ok;
	logic [NUM_BANKS-1:0] bank_err;
	logic [2*NUM_BANKS-1:0] bank_state_flat;

	// all banks share one precharge time; a new value applies from the next precharge
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			logic sel;
			// bank pins pick one bank; precharge with the auto bit reaches every bank
			assign sel = (ba_s == BANK_W'(gi));
			sdbrc_bank u_bank (
				.pclk(pclk),
				.presetn(presetn),
				.tick(tick),
				.act(is_act && sel),
				.col(is_col && sel),
				.auto_pre(addr_s[ADDR_AP_BIT]),
				.pre(is_pre && (sel || addr_s[ADDR_AP_BIT])),
				.row(addr_s),
				.trp(trp_reg),
				.state(bank_state[gi]),
				.open_row(bank_row[gi]),
				.access_ok(bank_ok[gi]),
				.err(bank_err[gi])
			);
			assign bank_state_flat[2*gi +: 2] = bank_state[gi];
		end
	endgenerate

	// ************************************************************
	// burst issue and column spacing
	// ************************************************************
	logic [2:0] gap_reg;
	logic ccd_err_reg;

	// link cycles since the last column command, saturating
	// a refused column command still restarts the spacing count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_reg <= CCD_CYCLES;
			ccd_err_reg <= 1'b0;
		end else begin
			ccd_err_reg <= is_col && (gap_reg < CCD_CYCLES);
			if (is_col) begin
				gap_reg <= 3'h1;
			end else if (tick && gap_reg < CCD_CYCLES) begin
				gap_reg <= gap_reg + 3'h1;
			end
		end
	end

	// burst handed on only when its bank holds an open row
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_valid <= 1'b0;
			burst_write <= 1'b0;
			burst_eight <= 1'b0;
			burst_auto_pre <= 1'b0;
			burst_bank <= '0;
			burst_row <= '0;
			burst_col <= '0;
		end else begin
			burst_valid <= |bank_ok;
			if (|bank_ok) begin
				burst_write <= is_wr;
				burst_eight <= addr_s[ADDR_BURST_BIT];
				burst_auto_pre <= addr_s[ADDR_AP_BIT];
				burst_bank <= ba_s;
				burst_row <= bank_row[ba_s];
				// column taken from the low bits alone; bit 12 never joins it
				burst_col <= addr_s[COL_W-1:0];
			end
		end
	end

	// ************************************************************
	// error tally: bad commands are counted, never fatal; early column commands still pass
	// ************************************************************
	logic [15:0] err_cnt_reg;
	logic err_clr;
	logic err_hit;

	assign err_hit = (|bank_err) || ccd_err_reg;

	// a hit in the clear cycle survives as a count of one
	// the count saturates rather than wrapping back to a clean-looking zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_cnt_reg <= 16'h0000;
		end else if (err_clr) begin
			err_cnt_reg <= err_hit ? 16'h0001 : 16'h0000;
		end else if (err_hit && err_cnt_reg != 16'hffff) begin
			err_cnt_reg <= err_cnt_reg + 16'h0001;
		end
	end

	// ************************************************************
	// apb slave
	// ************************************************************
	function automatic logic reg_mapped(input logic [7:0] a);
		reg_mapped = (a == REG_CTRL) || (a == REG_TRP) || (a == REG_MODE) ||
			(a == REG_BANKS) || (a == REG_ERRS);
	endfunction

	logic wr_en;

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_mapped(paddr);
	assign wr_en = psel && penable && pwrite && reg_mapped(paddr);
	assign err_clr = wr_en && (paddr == REG_CTRL) && pwdata[CTRL_CLR_BIT];

	// precharge time in link cycles; zero would stall nothing, so keep one minimum
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trp_reg <= TRP_RESET;
		end else if (wr_en && paddr == REG_TRP) begin
			trp_reg <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
		end
	end

	// read data captured in the setup cycle, stable through the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				REG_TRP: prdata <= {24'h000000, trp_reg};
				REG_MODE: prdata <= {26'h0000000, sr_mode_illegal, hot_s, sr_rate,
					self_refresh_temp_range_reg, auto_self_refresh_reg};
				REG_BANKS: prdata <= {16'h0000, bank_state_flat};
				REG_ERRS: prdata <= {16'h0000, err_cnt_reg};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// ==== verif/sdbrc_checker.sv ====
`timescale 1ns/100ps
// ****
// port checker
// ****
module sdbrc_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ddr_ck,
	input wire logic ddr_cke,
	input wire logic ddr_cs_n,
	input wire logic ddr_ras_n,
	input wire logic ddr_cas_n,
	input wire logic ddr_we_n,
	input wire logic [sdbrc_pkg::BANK_W-1:0] ddr_ba,
	input wire logic [sdbrc_pkg::ROW_W-1:0] ddr_addr,
	input wire logic temp_hot,
	input wire logic [1:0] sr_rate,
	input wire logic sr_mode_illegal,
	input wire logic burst_valid,
	input wire logic burst_write,
	input wire logic burst_eight,
	input wire logic burst_auto_pre,
	input wire logic [sdbrc_pkg::BANK_W-1:0] burst_bank,
	input wire logic [sdbrc_pkg::ROW_W-1:0] burst_row,
	input wire logic [sdbrc_pkg::COL_W-1:0] burst_col
);
	import sdbrc_pkg::*;
	// pins looked at four pclk back sit inside their hold window around the link rise
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_ck_rise;
		!ddr_ck ##1 ddr_ck;
	endsequence
	sequence s_nop_tick;
		s_ck_rise ##0 ddr_cs_n;
	endsequence
	chk_burst_hold: assert property (!burst_valid |-> $stable({burst_write, burst_eight,
		burst_auto_pre, burst_bank, burst_row, burst_col}))
		else $error("burst fields moved without a burst");
	chk_illegal_ext: assert property (sr_mode_illegal |-> sr_rate == SR_RATE_EXT)
		else $error("illegal mode not on extended rate");
	chk_auto_temp: assert property (((sr_rate == SR_RATE_AUTO_COOL && temp_hot) ||
		(sr_rate == SR_RATE_AUTO_HOT && !temp_hot))[*8] |-> 1'b0)
		else $error("auto rate ignores temperature");
	chk_burst_bank: assert property (burst_valid |-> burst_bank == $past(ddr_ba, 4))
		else $error("burst bank wrong");
	chk_col_bits: assert property (burst_valid |-> burst_col == $past(ddr_addr[9:0], 4))
		else $error("burst column wrong");
	chk_burst_len: assert property (burst_valid |->
		burst_eight == $past(ddr_addr[ADDR_BURST_BIT], 4))
		else $error("burst length wrong");
	chk_cmd_decode: assert property (burst_valid |->
		$past(!ddr_cs_n && ddr_cke && ddr_ras_n && !ddr_cas_n, 4) &&
		burst_write == !$past(ddr_we_n, 4) &&
		burst_auto_pre == $past(ddr_addr[ADDR_AP_BIT], 4))
		else $error("burst without matching column command");
	chk_nop_quiet: assert property (s_nop_tick |-> !burst_valid[*8])
		else $error("burst on a deselected tick");
endmodule
bind sdbrc_top sdbrc_checker u_chk (.pclk(pclk), .presetn(presetn), .ddr_ck(ddr_ck),
	.ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n),
	.ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr), .temp_hot(temp_hot),
	.sr_rate(sr_rate), .sr_mode_illegal(sr_mode_illegal), .burst_valid(burst_valid),
	.burst_write(burst_write), .burst_eight(burst_eight), .burst_auto_pre(burst_auto_pre),
	.burst_bank(burst_bank), .burst_row(burst_row), .burst_col(burst_col));

// ==== verif/sdbrc_ctl_model.sv ====
`timescale 1ns/100ps
// ****
// controller side of the command bus
// ****
module sdbrc_ctl_model (
	output logic ddr_ck,
	output logic ddr_cke,
	output logic ddr_cs_n,
	output logic ddr_ras_n,
	output logic ddr_cas_n,
	output logic ddr_we_n,
	output logic [sdbrc_pkg::BANK_W-1:0] ddr_ba,
	output logic [sdbrc_pkg::ROW_W-1:0] ddr_addr
);
	import sdbrc_pkg::*;
	// parked bus: clock low, deselected
	initial begin
		ddr_ck = 1'b0;
		ddr_cke = 1'b1;
		ddr_cs_n = 1'b1;
		{ddr_ras_n, ddr_cas_n, ddr_we_n} = 3'h7;
		ddr_ba = '0;
		ddr_addr = '0;
	end
	// one 160 ns link clock per command, still between commands
	task automatic send(input logic sel_n, input logic [2:0] op, input logic [2:0] ba,
			input logic [13:0] a);
		#3.3;
		ddr_cs_n = sel_n;
		{ddr_ras_n, ddr_cas_n, ddr_we_n} = op;
		ddr_ba = ba;
		ddr_addr = a;
		#80 ddr_ck = 1'b1;
		#80 ddr_ck = 1'b0;
		// released lines invert so a stale value never looks valid
		ddr_cs_n = 1'b1;
		{ddr_ras_n, ddr_cas_n, ddr_we_n} = ~op;
		ddr_ba = ~ba;
		ddr_addr = ~a;
	endtask
endmodule

// ==== verif/sdbrc_top_tb_top.sv ====
`timescale 1ns/100ps
module sdbrc_top_tb_top;
	import sdbrc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, temp_hot, pready, pslverr, e;
	logic ddr_ck, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
	logic sr_mode_illegal, burst_valid, burst_write, burst_eight, burst_auto_pre;
	logic [1:0] sr_rate;
	logic [2:0] ddr_ba, burst_bank, b;
	logic [7:0] paddr;
	logic [9:0] burst_col;
	logic [13:0] ddr_addr, burst_row, rw, orow[8];
	logic [29:0] got[$], exp_q[$];
	logic [31:0] pwdata, prdata, r, er;
	int miscompares = 0, checked = 0, errs = 0, gap = 9, trp = 6, st[8], cnt[8];
	integer seed = 32'h292b0349;
	// ****
	// design and far side
	// ****
	sdbrc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n),
		.ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba),
		.ddr_addr(ddr_addr), .temp_hot(temp_hot), .sr_rate(sr_rate),
		.sr_mode_illegal(sr_mode_illegal), .burst_valid(burst_valid),
		.burst_write(burst_write), .burst_eight(burst_eight), .burst_auto_pre(burst_auto_pre),
		.burst_bank(burst_bank), .burst_row(burst_row), .burst_col(burst_col));
	sdbrc_ctl_model ctl (.ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n),
		.ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba),
		.ddr_addr(ddr_addr));
	// 100 MHz system clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// every announced burst is queued for comparison
	always @(posedge pclk) begin
		if (burst_valid === 1'b1) begin
			got.push_back({burst_write, burst_eight, burst_auto_pre, burst_bank, burst_row,
				burst_col});
		end
	end
	task automatic check(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			miscompares++;
			$display("MISMATCH at %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic conclude();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// apb transfer: request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1) begin
			miscompares++;
			conclude();
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic err;
		apb(1'b0, a, 32'h0, q, err);
		check(q, x);
	endtask
	function automatic logic [31:0] bw();
		bw = '0;
		for (int i = 0; i < 8; i++) begin
			bw[2*i +: 2] = st[i][1:0];
		end
	endfunction
	// one link tick: reference model, then the wire, then the bursts seen
	task automatic issue(input logic sel_n, input logic [2:0] op, input logic [2:0] bk,
			input logic [13:0] a);
		for (int i = 0; i < 8; i++) begin
			if (st[i] == 2) begin
				if (cnt[i] == 1) st[i] = 0;
				else cnt[i]--;
			end
		end
		gap++;
		if (!sel_n) begin
			case (op)
				CMD_ACT: begin
					if (st[bk] != 0) errs++;
					else begin
						st[bk] = 1;
						orow[bk] = a;
					end
				end
				CMD_PRE: begin
					for (int i = 0; i < 8; i++) begin
						if ((i == bk || a[ADDR_AP_BIT]) && st[i] != 0) begin
							st[i] = 2;
							cnt[i] = trp;
						end
					end
				end
				CMD_RD, CMD_WR: begin
					// refused or early counts once; either way the spacing restarts
					if (st[bk] != 1 || gap < 4) errs++;
					gap = 0;
					if (st[bk] == 1) begin
						exp_q.push_back({op == CMD_WR, a[12], a[10], bk, orow[bk], a[9:0]});
						if (a[ADDR_AP_BIT]) begin
							st[bk] = 2;
							cnt[bk] = trp;
						end
					end
				end
				default: ;
			endcase
		end
		ctl.send(sel_n, op, bk, a);
		repeat (3) @(posedge pclk);
		check(got.size(), exp_q.size());
		while (got.size() > 0 && exp_q.size() > 0) begin
			check({2'h0, got.pop_front()}, {2'h0, exp_q.pop_front()});
		end
		exp_q.delete();
		got.delete();
	endtask
	task automatic nops(input int n);
		repeat (n) issue(1'b1, 3'h7, 3'h0, 14'h0);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		{psel, penable, pwrite, paddr, pwdata, temp_hot, presetn} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(REG_TRP, 32'h6);
		apb(1'b0, 8'h14, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		// every auto/range setting, each at both temperatures
		for (int k = 0; k < 8; k++) begin
			temp_hot <= k[2];
			issue(1'b0, CMD_MRS, MR_TWO_BANK, {6'h0, k[1], k[0], 6'h0});
			er = (k[0] && !k[1]) ? 2 + k[2] : k[1];
			check({30'h0, sr_rate}, er);
			rd(REG_MODE, {k[0] && k[1], k[2], er[1:0], k[1], k[0]});
		end
		// open a bank, read and write bursts at both lengths, then refusals around precharge
		apb(1'b1, REG_TRP, 32'h3, r, e);
		trp = 3;
		b = 3'($random(seed));
		rw = 14'($random(seed));
		issue(1'b0, CMD_ACT, b, rw);
		issue(1'b0, CMD_ACT, b, ~rw);
		for (int k = 0; k < 4; k++) begin
			nops(3);
			r = $random(seed);
			r[10] = 1'b0;
			r[12] = k[1];
			issue(1'b0, k[0] ? CMD_WR : CMD_RD, b, r[13:0]);
		end
		issue(1'b0, CMD_RD, b, 14'h1000);
		rd(REG_BANKS, bw());
		rd(REG_ERRS, 32'(errs));
		issue(1'b0, CMD_PRE, b, 14'h0);
		issue(1'b0, CMD_RD, b, 14'h1000);
		issue(1'b0, CMD_PRE, b, 14'h0);
		issue(1'b0, CMD_ACT, b, rw);
		rd(REG_BANKS, bw());
		nops(1);
		rd(REG_BANKS, bw());
		issue(1'b0, CMD_ACT, b, rw);
		nops(3);
		issue(1'b0, CMD_WR, b, 14'h1400);
		issue(1'b0, CMD_PRE, b + 3'h1, 14'h0);
		issue(1'b0, CMD_PRE, b + 3'h2, 14'h0400);
		nops(2);
		rd(REG_BANKS, bw());
		issue(1'b0, CMD_RD, b + 3'h1, 14'h0);
		rd(REG_BANKS, bw());
		rd(REG_ERRS, 32'(errs));
		apb(1'b1, REG_CTRL, 32'h1, r, e);
		errs = 0;
		rd(REG_ERRS, 32'(errs));
		issue(1'b0, CMD_ACT, b + 3'h1, rw);
		// full reset after the violations brings every default back
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		trp = 6;
		gap = 9;
		for (int i = 0; i < 8; i++) begin
			st[i] = 0;
		end
		rd(REG_TRP, 32'h6);
		rd(REG_BANKS, bw());
		issue(1'b0, CMD_ACT, b, rw);
		rd(REG_BANKS, bw());
		rd(REG_ERRS, 32'(errs));
		conclude();
	end
endmodule
